// ### design/hpt_regs.vh
// constants for the multiplexed wide host bus port
// assumes a 125 MHz core clock and an 8 bit decoded address space
`ifndef HPT_REGS_VH
`define HPT_REGS_VH
// address decode
`define HPT_ADDR_W 8
`define HPT_REGION_FIFO 2'b10
`define HPT_REGION_TOP 2'b11
// counter locations inside the normal region (word aligned)
`define HPT_ZCNT_WORD 6'h01
`define HPT_FCNT_WORD 6'h03
// long read strobe for the top region, in core clocks
`define HPT_TOP_RD_CLK 5
// reset values
`define HPT_ADDR_RST 8'h00
`define HPT_ZCNT_RST 32'h0000_0000
`define HPT_FCNT_RST 16'h0000
`endif

// ### design/hpt_port.v
// host bus port, multiplexed address/data, 8/16/32 bit byte lanes,
// with a small transmit fifo in front of the fifo-data sink.
// assumes all pin inputs are already synchronous to i_clk.
`timescale 1ns/1ps
`include "hpt_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// show-ahead fifo; the output stage is a register so the head is a flop
module hpt_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    output reg o_valid,
    input wire i_ready,
    output reg [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_ff;
    reg [AW-1:0] rd_ptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;
    wire load;

    assign o_ready = (count_ff != DEPTH[AW:0]);
    assign push = i_valid && o_ready;
    // head register refills whenever it is empty or being taken
    assign load = (count_ff != {(AW+1){1'b0}}) && (!o_valid || i_ready);
    assign pop = load;

    // storage array needs no reset
    always @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_data;
        end
    end

    // pointers, fill level and head register
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            o_valid <= 1'b0;
            o_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                o_data <= mem_ff[rd_ptr_ff];
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
            if (load) begin
                o_valid <= 1'b1;
            end else if (i_ready) begin
                o_valid <= 1'b0;
            end
        end
    end
endmodule // hpt_fifo

////////////////////////////////////////////////////////////////////////////////
module hpt_port #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_ale,
    input wire i_cs_n,
    input wire i_rd_n,
    input wire i_wr_n,
    input wire [3:0] i_lane_enable_n,
    input wire [31:0] i_ad,
    output reg [31:0] o_ad,
    output reg [3:0] o_ad_oe,
    output reg o_fifo_full,
    output reg o_reg_wr,
    output reg o_reg_rd,
    output reg [7:0] o_reg_addr,
    output reg [7:0] o_reg_wdata,
    input wire [7:0] i_reg_rdata,
    input wire [31:0] i_rx_data,
    output reg o_rx_pop,
    output reg [3:0] o_rx_lanes,
    output wire o_tx_valid,
    output wire [31:0] o_tx_data,
    output wire [3:0] o_tx_lanes,
    input wire i_tx_ready
);
    reg [7:0] addr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wlanes_ff;
    reg wr_prev_ff;
    reg rd_prev_ff;
    reg [2:0] rd_cnt_ff;
    reg [31:0] zcnt_ff;
    reg [15:0] fcnt_ff;
    reg [31:0] nxt_ad;
    reg [3:0] nxt_oe;
    reg [7:0] wbyte;
    reg [2:0] nbytes;
    wire rd_act;
    wire wr_act;
    wire wr_end;
    wire rd_end;
    wire in_fifo;
    wire in_top;
    wire is_zcnt;
    wire is_fcnt;
    wire fifo_ready;
    wire fifo_push;
    wire [35:0] fifo_out;
    integer k;
    integer kw;
    integer kn;

    ////////////////////////////////////////////////////////////////////////////
    // strobes: chip select is folded into each direction
    assign rd_act = !i_cs_n && !i_rd_n && i_wr_n;
    assign wr_act = !i_cs_n && !i_wr_n;
    assign wr_end = wr_prev_ff && !wr_act;
    assign rd_end = rd_prev_ff && !rd_act;
    assign in_fifo = (addr_ff[7:6] == `HPT_REGION_FIFO);
    assign in_top = (addr_ff[7:6] == `HPT_REGION_TOP);
    assign is_zcnt = !addr_ff[7] && (addr_ff[7:2] == `HPT_ZCNT_WORD);
    assign is_fcnt = !addr_ff[7] && (addr_ff[7:2] == `HPT_FCNT_WORD);
    // a full fifo refuses the push; the busy pin tells the host to back off
    assign fifo_push = wr_end && in_fifo && (wlanes_ff != 4'h0);

    // address phase; the upper 24 lines are never looked at
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_ff <= `HPT_ADDR_RST;
        end else if (i_ale) begin
            addr_ff <= i_ad[7:0];
        end
        // no else: address held for repeated data phases
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data phase: lanes sampled while the strobe is low, so the value
    // present just before the trailing edge is what gets used
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wdata_ff <= 32'h0000_0000;
            wlanes_ff <= 4'h0;
            wr_prev_ff <= 1'b0;
        end else begin
            wr_prev_ff <= wr_act;
            if (wr_act) begin
                wlanes_ff <= ~i_lane_enable_n;
                for (kw = 0; kw < 4; kw = kw + 1) begin
                    if (!i_lane_enable_n[kw]) begin
                        wdata_ff[kw*8 +: 8] <= i_ad[kw*8 +: 8];
                    end
                end
            end
        end
    end

    // byte for a single-lane register write: lane named by address bits
    always @* begin
        wbyte = wdata_ff[{addr_ff[1:0], 3'b000} +: 8];
    end

    // register write pulse at the trailing edge; fifo region goes to the fifo
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_wr <= 1'b0;
            o_reg_wdata <= 8'h00;
            o_reg_addr <= `HPT_ADDR_RST;
        end else begin
            o_reg_wr <= wr_end && !in_fifo && wlanes_ff[addr_ff[1:0]];
            if (wr_end || (rd_act && !rd_prev_ff)) begin
                o_reg_addr <= addr_ff;
            end
            if (wr_end) begin
                o_reg_wdata <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit fifo: one entry holds a word plus its lane mask
    hpt_fifo #(
        .WIDTH(36),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_valid(fifo_push),
        .o_ready(fifo_ready),
        .i_data({wlanes_ff, wdata_ff}),
        .o_valid(o_tx_valid),
        .i_ready(i_tx_ready),
        .o_data(fifo_out)
    );
    assign o_tx_data = fifo_out[31:0];
    assign o_tx_lanes = fifo_out[35:32];

    // count of bytes pushed per enabled lane
    always @* begin
        nbytes = 3'd0;
        for (kn = 0; kn < 4; kn = kn + 1) begin
            nbytes = nbytes + {2'b00, wlanes_ff[kn]};
        end
    end

    // z-counter counts accepted bytes, f-counter counts drained words
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            zcnt_ff <= `HPT_ZCNT_RST;
            fcnt_ff <= `HPT_FCNT_RST;
            o_fifo_full <= 1'b0;
        end else begin
            if (fifo_push && fifo_ready) begin
                zcnt_ff <= zcnt_ff + {29'h0, nbytes};
            end
            if (o_tx_valid && i_tx_ready) begin
                fcnt_ff <= fcnt_ff + 16'h0001;
            end
            o_fifo_full <= !fifo_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and lane drivers; counters and fifo allow wide reads,
    // f-counter only the low half, anything else only its own lane
    always @* begin
        nxt_ad = 32'h0000_0000;
        nxt_oe = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            if (in_fifo) begin
                nxt_ad[k*8 +: 8] = i_rx_data[k*8 +: 8];
                nxt_oe[k] = 1'b1;
            end else if (is_zcnt) begin
                nxt_ad[k*8 +: 8] = zcnt_ff[k*8 +: 8];
                nxt_oe[k] = 1'b1;
            end else if (is_fcnt) begin
                nxt_ad[k*8 +: 8] = (k < 2) ? fcnt_ff[(k%2)*8 +: 8] : 8'h00;
                nxt_oe[k] = (k < 2);
            end else begin
                nxt_ad[k*8 +: 8] = i_reg_rdata;
                nxt_oe[k] = (addr_ff[1:0] == k[1:0]);
            end
            // drive only under an enabled lane and a live read strobe
            nxt_oe[k] = nxt_oe[k] && rd_act && !i_lane_enable_n[k];
        end
        // top region data is not ready until the strobe is long enough
        if (in_top && (rd_cnt_ff < `HPT_TOP_RD_CLK - 1)) begin
            nxt_ad = 32'h0000_0000;
        end
    end

    // output stage, strobe length counter, end-of-read fifo pop
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ad <= 32'h0000_0000;
            o_ad_oe <= 4'h0;
            rd_prev_ff <= 1'b0;
            rd_cnt_ff <= 3'd0;
            o_reg_rd <= 1'b0;
            o_rx_pop <= 1'b0;
            o_rx_lanes <= 4'h0;
        end else begin
            o_ad <= nxt_ad;
            o_ad_oe <= nxt_oe;
            rd_prev_ff <= rd_act;
            if (!rd_act) begin
                rd_cnt_ff <= 3'd0;
            end else if (rd_cnt_ff != 3'd7) begin
                rd_cnt_ff <= rd_cnt_ff + 3'd1;
            end
            // all enables high is no access: no read side effects at all
            o_reg_rd <= rd_act && !rd_prev_ff && !in_fifo && (i_lane_enable_n != 4'hf);
            o_rx_pop <= rd_end && in_fifo && (o_rx_lanes != 4'h0);
            if (rd_act) begin
                o_rx_lanes <= ~i_lane_enable_n;
            end
        end
    end
endmodule // hpt_port

// ### bench/hpt_port_properties.sv
// pin-level checker for hpt_port
// assumes one clock and the async active-low reset
`timescale 1ns/1ps
module hpt_chk (
    input wire i_clk,
    input wire i_reset_n,
    input wire i_ale,
    input wire i_cs_n,
    input wire i_rd_n,
    input wire i_wr_n,
    input wire [3:0] i_lane_enable_n,
    input wire [31:0] i_ad,
    input wire [31:0] o_ad,
    input wire [3:0] o_ad_oe,
    input wire o_fifo_full,
    input wire o_reg_wr,
    input wire o_reg_rd,
    input wire [7:0] o_reg_addr,
    input wire o_tx_valid,
    input wire o_rx_pop
);
wire rd_act = !i_cs_n && !i_rd_n && i_wr_n;
wire wr_act = !i_cs_n && !i_wr_n;
wire [31:0] oe_mask = {{8{o_ad_oe[3]}}, {8{o_ad_oe[2]}}, {8{o_ad_oe[1]}}, {8{o_ad_oe[0]}}};
reg [7:0] lat_ff;
// own copy of the address, upper lines dropped so junk there cannot leak in
always @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) lat_ff <= 8'h00;
    else if (i_ale) lat_ff <= i_ad[7:0];
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
sequence s_wr_lane;
    wr_act && lat_ff[7:6] != 2'b10 && !i_lane_enable_n[lat_ff[1:0]] ##1 !wr_act;
endsequence
sequence s_top_rd;
    !rd_act ##1 rd_act && lat_ff[7:6] == 2'b11 ##1 rd_act;
endsequence
AST_OE_CAUSE: assert property (o_ad_oe != 4'h0 |-> $past(rd_act) && (o_ad_oe & $past(i_lane_enable_n)) == 4'h0)
    else $error("lane driven without enabled read");
AST_RD_RELEASE: assert property ($fell(rd_act) |=> o_ad_oe == 4'h0)
    else $error("lanes still driven after read");
AST_ONE_LANE: assert property (o_ad_oe != 4'h0 && !lat_ff[7] && lat_ff[7:2] != 6'h01 && lat_ff[7:2] != 6'h03
    |-> o_ad_oe == (4'h1 << lat_ff[1:0])) else $error("register read lane wrong");
AST_WR_TAKEN: assert property (s_wr_lane |-> ##[1:2] o_reg_wr)
    else $error("register write not taken");
AST_WR_CAUSE: assert property (o_reg_wr |-> ($past(wr_act, 2) || $past(wr_act, 3)) && o_reg_addr == lat_ff)
    else $error("register write without strobe");
AST_TOP_ZERO: assert property (s_top_rd |-> (o_ad & oe_mask) == 32'h0)
    else $error("top region data too early");
AST_FCNT_LANES: assert property (rd_act && lat_ff[7:2] == 6'h03 |=> o_ad_oe[3:2] == 2'b00)
    else $error("counter upper lanes driven");
AST_POP: assert property (o_rx_pop |-> lat_ff[7:6] == 2'b10 && ($past(o_ad_oe) != 0 || $past(o_ad_oe, 2) != 0))
    else $error("pop without fifo read");
AST_FULL: assert property (o_fifo_full |-> o_tx_valid)
    else $error("full with empty head");
AST_RD_PULSE: assert property (o_reg_rd |-> $past(rd_act) && !$past(rd_act, 2)
    && $past(i_lane_enable_n) != 4'hf && lat_ff[7:6] != 2'b10) else $error("register read without access");
endmodule // hpt_chk
bind hpt_port hpt_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ale(i_ale), .i_cs_n(i_cs_n),
    .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_lane_enable_n(i_lane_enable_n), .i_ad(i_ad), .o_ad(o_ad),
    .o_ad_oe(o_ad_oe), .o_fifo_full(o_fifo_full), .o_reg_wr(o_reg_wr), .o_reg_rd(o_reg_rd),
    .o_reg_addr(o_reg_addr),
    .o_tx_valid(o_tx_valid), .o_rx_pop(o_rx_pop));

// ### bench/hpt_host.sv
// host processor model for the multiplexed bus
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module hpt_host (
    input wire i_clk,
    input wire [31:0] i_ad,
    input wire [3:0] i_oe,
    output reg o_ale = 1'b0,
    output reg o_cs_n = 1'b1,
    output reg o_rd_n = 1'b1,
    output reg o_wr_n = 1'b1,
    output reg [3:0] o_be_n = 4'hf,
    output reg [31:0] o_ad = 32'h0
);
// address phase, then the lines are turned to a changed pattern
task set_addr(input [7:0] a, input [23:0] junk);
    begin
        @(posedge i_clk);
        #1 o_ale = 1'b1;
        o_ad = {junk, a};
        @(posedge i_clk);
        #1 o_ale = 1'b0;
        o_ad = ~o_ad;
    end
endtask
// one-cycle write strobe; idle time covers the slowest fifo case
task wr(input [3:0] be, input [31:0] d);
    begin
        @(posedge i_clk);
        #1 o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        o_be_n = be;
        o_ad = d;
        @(posedge i_clk);
        #1 o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_be_n = 4'hf;
        o_ad = ~d;
        repeat (7) @(posedge i_clk);
    end
endtask
// read held for n edges, answer taken at the last one
task rd(input [3:0] be, input integer n, output [31:0] d, output [3:0] oe);
    reg [31:0] m;
    begin
        @(posedge i_clk);
        #1 o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        o_be_n = be;
        repeat (n) @(posedge i_clk);
        // undriven lanes read back inverted so a missing enable cannot pass
        #1 m = {{8{i_oe[3]}}, {8{i_oe[2]}}, {8{i_oe[1]}}, {8{i_oe[0]}}};
        d = i_ad ^ ~m;
        oe = i_oe;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_be_n = 4'hf;
        repeat (9) @(posedge i_clk);
    end
endtask
endmodule // hpt_host

// ### bench/tb_top.sv
// self-checking bench for hpt_port
// assumes the host model drives every bus pin
`timescale 1ns/1ps
module tb_top;
reg i_clk = 1'b0;
reg i_reset_n = 1'b0;
reg [7:0] reg_rdata = 8'h00;
reg [31:0] rx_data = 32'h0;
reg tx_ready = 1'b0;
wire ale, cs_n, rd_n, wr_n, full, reg_wr, reg_rd, rx_pop, tx_valid;
wire [3:0] be_n, oe, rx_lanes, tx_lanes;
wire [31:0] ad_h, ad_d, tx_data;
wire [7:0] reg_addr, reg_wdata;
integer error_cnt = 0;
integer tests_run = 0;
integer wr_cnt = 0;
integer pop_cnt = 0;
integer rd_pulse_cnt = 0;
reg [31:0] d;
reg [3:0] ln;
always #4 i_clk = ~i_clk;
hpt_host u_host (.i_clk(i_clk), .i_ad(ad_d), .i_oe(oe), .o_ale(ale), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_be_n(be_n), .o_ad(ad_h));
hpt_port u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ale(ale), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_lane_enable_n(be_n), .i_ad(ad_h), .o_ad(ad_d), .o_ad_oe(oe), .o_fifo_full(full),
    .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata), .i_rx_data(rx_data), .o_rx_pop(rx_pop), .o_rx_lanes(rx_lanes),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_lanes(tx_lanes), .i_tx_ready(tx_ready));
// pulses counted on the falling edge, well clear of the launching edge
always @(negedge i_clk) begin
    if (reg_wr === 1'b1) wr_cnt = wr_cnt + 1;
    if (rx_pop === 1'b1) pop_cnt = pop_cnt + 1;
    if (reg_rd === 1'b1) rd_pulse_cnt = rd_pulse_cnt + 1;
end
task check(input string name, input [31:0] exp, input [31:0] got);
    begin
        tests_run = tests_run + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %0s exp %h got %h", name, exp, got);
        end
    end
endtask
task end_of_test;
    begin
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
endtask
// take one head word; lanes not enabled are masked off
task pop(input [3:0] le, input [31:0] mask, input [31:0] de);
    integer n;
    begin
        n = 0;
        @(posedge i_clk);
        #1;
        while (tx_valid !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            #1 n = n + 1;
        end
        if (n == 20) begin
            error_cnt = error_cnt + 1;
            end_of_test;
        end
        check("tx lanes", le, tx_lanes);
        check("tx data", de, tx_data & mask);
        tx_ready = 1'b1;
        @(posedge i_clk);
        #1 tx_ready = 1'b0;
    end
endtask
task t_reg_write;
    begin
        u_host.set_addr(8'h31, 24'habcdef);
        u_host.wr(4'hd, 32'h11223344);
        check("wdata", 32'h33, reg_wdata);
        check("addr", 32'h31, reg_addr);
        u_host.wr(4'hd, 32'h55667788);
        check("wdata again", 32'h77, reg_wdata);
        u_host.wr(4'he, 32'h99aabbcc);
        check("write pulses", 2, wr_cnt);
        $display("test reg_write done");
    end
endtask
task t_fifo;
    integer i;
    begin
        u_host.set_addr(8'h80, 24'h0);
        u_host.wr(4'h0, 32'ha1b2c3d4);
        u_host.set_addr(8'h82, 24'h0);
        u_host.wr(4'h3, 32'h55667788);
        u_host.set_addr(8'h81, 24'h0);
        for (i = 0; i < 4; i = i + 1) u_host.wr(4'hd, 32'h00009900);
        check("full", 1, full);
        pop(4'hf, 32'hffffffff, 32'ha1b2c3d4);
        pop(4'hc, 32'hffff0000, 32'h55660000);
        for (i = 0; i < 3; i = i + 1) pop(4'h2, 32'h0000ff00, 32'h00009900);
        repeat (4) @(posedge i_clk);
        #1 check("empty", 0, tx_valid);
        u_host.set_addr(8'h04, 24'h0);
        u_host.rd(4'h0, 1, d, ln);
        check("z count", 9, d);
        check("z lanes", 4'hf, ln);
        u_host.set_addr(8'h0c, 24'h0);
        u_host.rd(4'h0, 1, d, ln);
        check("f count", 5, d[15:0]);
        check("f lanes", 4'h3, ln);
        $display("test fifo done");
    end
endtask
task t_reads;
    begin
        #1 reg_rdata = 8'h5a;
        u_host.set_addr(8'h12, 24'h0);
        u_host.rd(4'h0, 1, d, ln);
        check("rd lanes", 4'h4, ln);
        check("rd data", 32'h5a, d[23:16]);
        u_host.rd(4'hb, 1, d, ln);
        check("reread", 32'h5a, d[23:16]);
        check("idle lanes", 0, oe);
        u_host.rd(4'hf, 1, d, ln);
        check("no access", 0, ln);
        #1 reg_rdata = 8'hc3;
        u_host.set_addr(8'hc5, 24'h0);
        u_host.rd(4'hd, 2, d, ln);
        check("top early", 0, d[15:8]);
        u_host.rd(4'hd, 7, d, ln);
        check("top data", 32'hc3, d[15:8]);
        #1 rx_data = 32'hdeadbeef;
        u_host.set_addr(8'h90, 24'h0);
        u_host.rd(4'hc, 1, d, ln);
        check("fifo rd", 32'hbeef, d[15:0]);
        check("pops", 1, pop_cnt);
        check("pop lanes", 4'h3, rx_lanes);
        u_host.rd(4'hf, 1, d, ln);
        check("no pop", 1, pop_cnt);
        check("reg reads", 6, rd_pulse_cnt);
        $display("test reads done");
    end
endtask
initial begin
    #200000 error_cnt = error_cnt + 1;
    end_of_test;
end
initial begin
    repeat (4) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    t_reg_write;
    t_fifo;
    t_reads;
    end_of_test;
end
endmodule // tb_top
